// ==== src/scs_pkg.sv ====
// shared constants and types for the conversion sequencer
package scs_pkg;

	// system clock and internal oscillator
	localparam int CLOCK_MHZ = 250;
	localparam int OSC_MIN_MHZ = 21;
	// longest oscillator period in system cycles, rounded down so the tick rate stays at or above the minimum
	localparam logic [3:0] OSC_DIV_CYCLES = 4'(CLOCK_MHZ / OSC_MIN_MHZ);

	// phase lengths in conversion clocks
	localparam logic [1:0] ACQ_CCLKS = 2'h3;
	localparam logic [4:0] CONV_CCLKS = 5'h12;

	// configuration field bit positions
	localparam int CFG_CHAN_MODE_BIT = 11;
	localparam int CFG_CLK_SRC_BIT = 10;
	localparam int CFG_TRIG_MODE_BIT = 9;
	localparam int CFG_DEEP_PD_BIT = 2;

	// configuration after reset: auto channel, internal clock, manual trigger, powered
	localparam logic [11:0] CFG_RESET = 12'h604;

	// command field codes
	localparam logic [3:0] CMD_CHAN0 = 4'h0;
	localparam logic [3:0] CMD_CHAN1 = 4'h1;
	localparam logic [3:0] CMD_WAKEUP = 4'hb;
	localparam logic [3:0] CMD_WRITE_CFG = 4'he;
	localparam logic [3:0] CMD_DEFAULT = 4'hf;

	// sequencer phases
	typedef enum logic [1:0] {
		SCS_SAMPLE = 2'b00,
		SCS_CONVERT = 2'b01,
		SCS_HALT = 2'b10
	} scs_phase_e;

	// one command word: command field then configuration field
	typedef struct packed {
		logic [3:0] command_field;
		logic [11:0] configuration_field;
	} scs_cmd_s;

	// whole state of the sequencer
	typedef struct packed {
		scs_phase_e phase;
		logic [1:0] acq_cnt;
		logic [4:0] conv_cnt;
		logic [3:0] osc_cnt;
		logic sclk_prev;
		logic sclk_half;
		logic start_prev;
		logic [11:0] cfg;
		logic channel;
		logic eoc_n;
		logic done;
	} scs_state_s;

	localparam scs_state_s STATE_RESET = '{
		phase: SCS_SAMPLE,
		acq_cnt: 2'h0,
		conv_cnt: 5'h00,
		osc_cnt: 4'h0,
		sclk_prev: 1'b0,
		sclk_half: 1'b0,
		start_prev: 1'b1,
		cfg: CFG_RESET,
		channel: 1'b0,
		eoc_n: 1'b1,
		done: 1'b0
	};

endpackage : scs_pkg

// ==== src/scs_sequencer.sv ====
// conversion timing and channel sequencing for a 12-bit sar converter
// Notes on behaviour
// - internal source ticks the conversion clock at 21 MHz or faster
// - oscillator runs except in deep power-down or with serial clock source
// - acquisition lasts at least 3 conversion clocks before conversion
// - conversion lasts 18 conversion clocks
// - serial clock source is halved to form the conversion clock
// - serial-clock timed conversion spans 35 or 36 serial clocks by start alignment
// - manual channel chosen by a command word, possibly only four serial clocks long
// - automatic channel selection is default and alternates channel 0 and 1
// - clearing the channel mode bit makes channel 0 acquired next
// - in manual trigger, start pin falling edge ends sampling and begins conversion
// - start pin acts independently of frame select
// - automatic trigger restarts after 3 acquisition clocks, 21 clocks per cycle
// - manual trigger: status low from start fall until conversion completes
// - command word is 4-bit command field then 12-bit configuration field
`timescale 1ns/1ps

module scs_sequencer (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// pins from the host
	input wire logic conversion_start_pin_n_in,
	input wire logic serial_clock_in,
	input wire logic frame_select_n_in,
	// decoded command word from the serial frame
	input wire logic command_valid_in,
	input wire scs_pkg::scs_cmd_s command_in,
	// status toward the host and analog core
	output logic end_of_conversion_n_out,
	output logic conversion_done_out,
	output logic converting_out,
	output logic channel_out,
	output logic oscillator_enable_out,
	output logic [11:0] configuration_out
);

	scs_pkg::scs_state_s st;
	scs_pkg::scs_state_s next_st;
	logic sclk_rise;
	logic start_fall;
	logic conversion_clock_tick;
	logic use_sclk;
	logic osc_run;
	logic manual_trigger;
	logic manual_channel;
	logic acq_ok;
	logic unused_frame;

	// frame select is deliberately not looked at by the start path
	// start independent of frame
	assign unused_frame = frame_select_n_in;

	// mode decode from the live configuration
	assign use_sclk = ~st.cfg[scs_pkg::CFG_CLK_SRC_BIT];
	assign manual_trigger = st.cfg[scs_pkg::CFG_TRIG_MODE_BIT];
	assign manual_channel = st.cfg[scs_pkg::CFG_CHAN_MODE_BIT];
	assign osc_run = st.cfg[scs_pkg::CFG_DEEP_PD_BIT] & ~use_sclk;

	// edge detectors; pins are taken as synchronous to clock_in
	assign sclk_rise = serial_clock_in & ~st.sclk_prev;
	assign start_fall = st.start_prev & ~conversion_start_pin_n_in;
	assign acq_ok = (st.acq_cnt == scs_pkg::ACQ_CCLKS);

	// conversion clock source: every second serial rise, or the oscillator divider
	always_comb begin
		if (use_sclk) begin
			conversion_clock_tick = sclk_rise & st.sclk_half;
		end else begin
			conversion_clock_tick = osc_run && (st.osc_cnt == scs_pkg::OSC_DIV_CYCLES - 4'h1);
		end
	end

	// next-state logic for the whole sequencer
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.sclk_prev = serial_clock_in;
		next_st.start_prev = conversion_start_pin_n_in;

		// divider state; halving phase only advances on serial rises
		if (use_sclk && sclk_rise) begin
			next_st.sclk_half = ~st.sclk_half;
		end
		// stopped oscillator holds its count at zero to restart clean
		if (!osc_run || conversion_clock_tick) begin
			next_st.osc_cnt = 4'h0;
		end else begin
			next_st.osc_cnt = st.osc_cnt + 4'h1;
		end

		// command handling
		// command then configuration field
		if (command_valid_in) begin
			case (command_in.command_field)
				scs_pkg::CMD_CHAN0, scs_pkg::CMD_CHAN1: begin
					if (manual_channel) begin
						next_st.channel = command_in.command_field[0];
					end
				end
				scs_pkg::CMD_WAKEUP: begin
					next_st.cfg[scs_pkg::CFG_DEEP_PD_BIT] = 1'b1;
				end
				scs_pkg::CMD_WRITE_CFG: begin
					next_st.cfg = command_in.configuration_field;
					if (!command_in.configuration_field[scs_pkg::CFG_CHAN_MODE_BIT]) begin
						next_st.channel = 1'b0;
					end
				end
				scs_pkg::CMD_DEFAULT: begin
					next_st.cfg = scs_pkg::CFG_RESET;
					next_st.channel = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// phase machine; decisions use the configuration already in force
		case (st.phase)
			scs_pkg::SCS_HALT: begin
				if (st.cfg[scs_pkg::CFG_DEEP_PD_BIT]) begin
					next_st.phase = scs_pkg::SCS_SAMPLE;
					next_st.acq_cnt = 2'h0;
				end
			end
			scs_pkg::SCS_SAMPLE: begin
				if (conversion_clock_tick && !acq_ok) begin
					next_st.acq_cnt = st.acq_cnt + 2'h1;
				end
				if (manual_trigger) begin
					// early edges are dropped, they would cut acquisition short
					// hold and convert on fall
					if (start_fall && acq_ok) begin
						next_st.phase = scs_pkg::SCS_CONVERT;
						next_st.conv_cnt = 5'h00;
						next_st.eoc_n = 1'b0;
					end
				end else begin
					if (acq_ok) begin
						next_st.phase = scs_pkg::SCS_CONVERT;
						next_st.conv_cnt = 5'h00;
						next_st.eoc_n = 1'b1;
					end
				end
			end
			scs_pkg::SCS_CONVERT: begin
				if (conversion_clock_tick) begin
					next_st.conv_cnt = st.conv_cnt + 5'h01;
					if (st.conv_cnt == scs_pkg::CONV_CCLKS - 5'h01) begin
						next_st.phase = scs_pkg::SCS_SAMPLE;
						next_st.acq_cnt = 2'h0;
						next_st.done = 1'b1;
						// auto trigger marks the acquisition window low instead
						next_st.eoc_n = manual_trigger;
						if (!manual_channel) begin
							next_st.channel = ~st.channel;
						end
					end
				end
			end
			default: begin
				next_st.phase = scs_pkg::SCS_SAMPLE;
			end
		endcase

		// deep power-down aborts any conversion in progress
		if (!st.cfg[scs_pkg::CFG_DEEP_PD_BIT]) begin
			next_st.phase = scs_pkg::SCS_HALT;
			next_st.acq_cnt = 2'h0;
			next_st.conv_cnt = 5'h00;
			next_st.eoc_n = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			st <= scs_pkg::STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state flops
	assign end_of_conversion_n_out = st.eoc_n;
	assign conversion_done_out = st.done;
	assign converting_out = (st.phase == scs_pkg::SCS_CONVERT);
	assign channel_out = st.channel;
	assign oscillator_enable_out = osc_run;
	assign configuration_out = st.cfg;

endmodule : scs_sequencer

// ==== test/scs_sequencer_props.sv ====
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module scs_sequencer_props (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// watched outputs
	input wire logic end_of_conversion_n_out,
	input wire logic conversion_done_out,
	input wire logic converting_out,
	input wire logic channel_out,
	input wire logic oscillator_enable_out,
	input wire logic [11:0] configuration_out
);
	logic [8:0] run;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// cycles in the current converting level, saturating over idle
	always_ff @(posedge clock_in or posedge rst_in)
		if (rst_in)
			run <= 9'h0;
		else
			run <= $changed(converting_out) ? 9'h1 : run + {8'h0, ~&run};
	sequence s_done;
		conversion_done_out ##1 !conversion_done_out;
	endsequence
	property p_done;
		$fell(converting_out) && configuration_out[2] |-> s_done;
	endproperty
	property p_len;
		$fell(converting_out) && configuration_out[10] |-> run inside {[9'hba:9'hc8]};
	endproperty
	property p_eoc;
		configuration_out[9] && (converting_out || $fell(converting_out)) |-> end_of_conversion_n_out != converting_out;
	endproperty
	property p_chan;
		$fell(converting_out) && !configuration_out[11] |-> channel_out != $past(channel_out);
	endproperty
	property p_osc;
		oscillator_enable_out == (configuration_out[2] && configuration_out[10]);
	endproperty
	property p_acq;
		$rose(converting_out) && configuration_out[10] |-> run >= 9'h16;
	endproperty
	property p_gap;
		$rose(converting_out) && !configuration_out[9] && !$past(end_of_conversion_n_out) |-> run inside {[9'h1e:9'h24]};
	endproperty
	property p_pulse;
		conversion_done_out |-> !converting_out && $past(converting_out);
	endproperty
	a_done: assert property (p_done) else $error("bad done");
	a_len: assert property (p_len) else $error("bad length");
	a_eoc: assert property (p_eoc) else $error("bad eoc");
	a_chan: assert property (p_chan) else $error("no toggle");
	a_osc: assert property (p_osc) else $error("bad osc");
	a_acq: assert property (p_acq) else $error("short acq");
	a_gap: assert property (p_gap) else $error("bad gap");
	a_pulse: assert property (p_pulse) else $error("stray done");
endmodule : scs_sequencer_props
bind scs_sequencer scs_sequencer_props u_props (.*);

// ==== test/scs_host.sv ====
// host model driving the start pin and serial clock
`timescale 1ns/1ps
module scs_host (
	// clock and bench requests
	input wire logic clock_in,
	input wire logic fire_in,
	input wire logic sclk_run_in,
	// pins toward the sequencer
	output logic start_n_out,
	output logic sclk_out
);
	logic [3:0] low = 4'h0;
	logic [1:0] div = 2'h0;
	// pin low 48 ns; 16 ns clock, idle low
	always_ff @(posedge clock_in) begin
		low <= fire_in ? 4'hc : low - {3'h0, |low};
		div <= sclk_run_in ? div + 2'h1 : 2'h0;
	end
	assign start_n_out = ~|low;
	assign sclk_out = div[1];
endmodule : scs_host

// ==== test/scs_sequencer_tb.sv ====
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
	$display("mismatch %0t %h %h", $time, a, e); end end
module scs_sequencer_tb;
	typedef struct packed {
		scs_pkg::scs_cmd_s word;
		logic [13:0] expect_out;
	} scs_row_s;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic fire = 1'b0;
	logic sclk_run = 1'b0;
	logic frame_select_n_in = 1'b1;
	logic command_valid_in = 1'b0;
	scs_pkg::scs_cmd_s command_in = 16'h0;
	logic conversion_start_pin_n_in, serial_clock_in, end_of_conversion_n_out, conversion_done_out;
	logic converting_out, channel_out, oscillator_enable_out;
	logic [11:0] configuration_out;
	int n_tests = 0;
	int miscompares = 0;
	int n;
	// command word, then configuration, channel and oscillator enable
	scs_row_s rows [8] = '{'{16'hee04, 14'h3811}, '{16'h1000, 14'h3813},
		'{16'he604, 14'h1811}, '{16'h1000, 14'h1811}, '{16'he600, 14'h1800},
		'{16'hb000, 14'h1811}, '{16'he204, 14'h0810}, '{16'hf000, 14'h1811}};
	scs_sequencer dut (.*);
	scs_host host (.clock_in(clock_in), .fire_in(fire), .sclk_run_in(sclk_run),
		.start_n_out(conversion_start_pin_n_in), .sclk_out(serial_clock_in));
	always #2 clock_in = ~clock_in;
	task automatic send(input scs_pkg::scs_cmd_s w);
		@(posedge clock_in);
		command_in <= w;
		command_valid_in <= 1'b1;
		@(posedge clock_in);
		command_valid_in <= 1'b0;
		@(negedge clock_in);
	endtask : send
	task automatic start(input logic fs);
		@(posedge clock_in);
		fire <= 1'b1;
		frame_select_n_in <= fs;
		@(posedge clock_in);
		fire <= 1'b0;
	endtask : start
	// cycles of the next conversion
	task automatic measure();
		n = 0;
		while (converting_out !== 1'b1)
			@(negedge clock_in);
		while (converting_out === 1'b1) begin
			@(negedge clock_in);
			n++;
		end
	endtask : measure
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// watchdog: tests need about 1000 cycles
	initial begin
		#20000;
		miscompares++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge clock_in);
		rst_in <= 1'b0;
		@(negedge clock_in);
		`CHK({configuration_out, end_of_conversion_n_out, conversion_done_out, converting_out, channel_out, oscillator_enable_out}, {scs_pkg::CFG_RESET, 5'h11})
		$display("reset test done");
		foreach (rows[i]) begin
			send(rows[i].word);
			`CHK({configuration_out, channel_out, oscillator_enable_out}, rows[i].expect_out)
			$display("row %0d done", i);
		end
		// waits keep 21 conversion clocks between accepted starts
		repeat (45) @(posedge clock_in);
		start(1'b1);
		measure();
		`CHK(n inside {[186:200]}, 1'b1)
		`CHK(channel_out, 1'b1)
		// a start right after the end falls in acquisition and is refused
		start(1'b1);
		repeat (20) @(negedge clock_in);
		`CHK(converting_out, 1'b0)
		repeat (45) @(posedge clock_in);
		start(1'b0);
		measure();
		`CHK(channel_out, 1'b0)
		$display("manual test done");
		send(16'he204);
		sclk_run <= 1'b1;
		repeat (60) @(posedge clock_in);
		start(1'b1);
		measure();
		`CHK(n inside {[137:150]}, 1'b1)
		sclk_run <= 1'b0;
		$display("serial test done");
		send(16'he404);
		measure();
		fork
			start(1'b1);
		join_none
		n = 0;
		while (converting_out !== 1'b1) begin
			@(negedge clock_in);
			n++;
		end
		// auto channel mode flips channel_out from 0 to 1 when the conversion ends
		`CHK(channel_out, 1'b1)
		// one extra system cycle passes between the third tick and the phase change
		`CHK(n, 34)
		$display("auto test done");
		summarize();
	end
endmodule : scs_sequencer_tb
